//--- logic/soe_cfg_pkg.sv
// Package: register map, field positions and timing for the contact input config/status bank
package soe_cfg_pkg;

  localparam logic [7:0]  CFG_STATUS_IDX   = 8'h0D;
  localparam logic [7:0]  CFG_STATUS_ADDR  = 8'h34;
  localparam logic [7:0]  IRQ_STATUS_ADDR  = 8'h40;
  localparam logic [7:0]  IRQ_ENABLE_ADDR  = 8'h44;
  localparam logic [7:0]  IRQ_CLEAR_ADDR   = 8'h48;
  localparam logic [7:0]  FIELD_IN_ADDR    = 8'h4C;
  localparam logic [7:0]  UNFREEZE_ADDR    = 8'h50;

  localparam int BIT_CONFIGURE   = 0;
  localparam int BIT_FORCE_ERR   = 1;
  localparam int BIT_FUSE_EN     = 6;
  localparam int BIT_FUSE_BLOWN  = 7;
  localparam int BIT_AUX_EN      = 8;
  localparam int BIT_AUX_FAIL    = 9;
  localparam int BIT_GND_ATT_EN  = 10;
  localparam int BIT_GND_FAULT   = 11;
  localparam int BIT_CHAT_DIS    = 12;
  localparam int BIT_CHAT_CLR    = 13;

  localparam logic [15:0] CFG_WRITE_MASK   = 16'h3543;
  localparam logic [15:0] CFG_RESET        = 16'h0000;

  localparam int IRQ_W          = 4;
  localparam int IRQ_FUSE       = 0;
  localparam int IRQ_AUX        = 1;
  localparam int IRQ_GND        = 2;
  localparam int IRQ_CHATTER    = 3;

  localparam int CHATTER_LIMIT  = 4;
  localparam int CLK_HZ         = 25_000_000;
  localparam int DECAY_MS       = 100;
  localparam int DECAY_CYCLES   = CLK_HZ / 1000 * DECAY_MS;
  localparam int COMM_MS        = 100;
  localparam int COMM_CYCLES    = CLK_HZ / 1000 * COMM_MS;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       fuse_blown;
    logic       aux_fail;
    logic       gnd_fault;
  } field_s;

endpackage : soe_cfg_pkg

//--- logic/soe_contact_cfg_status.sv
// Config/status bank, chatter supervision and indicators of a 16-channel contact input module
// Functional notes
// - Word 13 write loads config, read gives status
// - Chatter and event recording idle until config bit 0 set
// - Config bit 1 forces internal error, status-only reads
// - Status bit 1 reports forced error
// - Bit 6 enables blown fuse; host keeps clear
// - Status bit 7 shows blown fuse
// - Bit 8 enables aux failure and ground detection
// - Status bit 9 shows aux supply failure
// - Bit 10 ground attention enable; status 11 fault
// - Bit 12 disables chatter control, echoed
// - Bit 13 clears counters on unfreeze, else decay
// - Status bit 13 echoes counter reset policy
// - External fault indicator lit on ground fault
// - Internal fault indicator on aux fail, bit 8
// - Communications indicator lit while host active
// - Channel indicators lit while contact closed
// - Chatter at four changes or fast rate
`timescale 1ns/1ps
`default_nettype none

module soe_contact_cfg_status #(
  parameter int NUM_CH       = 16,
  parameter int DECAY_CYCLES = soe_cfg_pkg::DECAY_CYCLES,
  parameter int COMM_CYCLES  = soe_cfg_pkg::COMM_CYCLES
) (
  input  wire logic                 REF_CLK,
  input  wire logic                 RST_N,
  input  wire logic [7:0]           S_AXI_AWADDR,
  input  wire logic                 S_AXI_AWVALID,
  output logic                      S_AXI_AWREADY,
  input  wire logic [31:0]          S_AXI_WDATA,
  input  wire logic [3:0]           S_AXI_WSTRB,
  input  wire logic                 S_AXI_WVALID,
  output logic                      S_AXI_WREADY,
  output logic [1:0]                S_AXI_BRESP,
  output logic                      S_AXI_BVALID,
  input  wire logic                 S_AXI_BREADY,
  input  wire logic [7:0]           S_AXI_ARADDR,
  input  wire logic                 S_AXI_ARVALID,
  output logic                      S_AXI_ARREADY,
  output logic [31:0]               S_AXI_RDATA,
  output logic [1:0]                S_AXI_RRESP,
  output logic                      S_AXI_RVALID,
  input  wire logic                 S_AXI_RREADY,
  input  wire logic [NUM_CH-1:0]    CONTACT_CLOSED,
  input  wire soe_cfg_pkg::field_s  FIELD_FAULTS,
  output logic [NUM_CH-1:0]         CHANNEL_STATE_INDICATORS,
  output logic [NUM_CH-1:0]         CHATTER_FLAGS,
  output logic [NUM_CH-1:0]         EVENT_RECORD,
  output logic                      EXT_FAULT_LED,
  output logic                      INT_FAULT_LED,
  output logic                      COMM_LED,
  output logic                      MODULE_RUN,
  output logic                      IRQ
);

  if (NUM_CH < 1 || NUM_CH > 16 || DECAY_CYCLES < 2 || COMM_CYCLES < 2)
  begin : g_bad_param
    $error("NUM_CH must be 1..16 and counts at least 2");
  end

  // Pin synchronisers: stage 1 read only by stage 2
  logic [NUM_CH-1:0]   contact_s1_q, contact_s2_q, contact_prev_q;
  soe_cfg_pkg::field_s field_s1_q, field_s2_q;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      contact_s1_q   <= '0;
      contact_s2_q   <= '0;
      contact_prev_q <= '0;
      field_s1_q     <= '0;
      field_s2_q     <= '0;
    end
    else
    begin
      contact_s1_q   <= CONTACT_CLOSED;
      contact_s2_q   <= contact_s1_q;
      contact_prev_q <= contact_s2_q;
      field_s1_q     <= FIELD_FAULTS;
      field_s2_q     <= field_s1_q;
    end
  end

  // AXI4-Lite slave, single outstanding write and read
  logic [7:0]  aw_addr_q;
  logic        aw_have_q, w_have_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_fire;
  logic [15:0] cfg_q;
  logic [15:0] status;
  localparam int IRQ_BITS = soe_cfg_pkg::IRQ_W;
  logic [IRQ_BITS-1:0] irq_status_q, irq_enable_q, irq_events;
  logic        unfreeze_pulse;

  assign wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= soe_cfg_pkg::RESP_OKAY;
    end
    else
    begin
      S_AXI_AWREADY <= !aw_have_q && !S_AXI_AWREADY;
      S_AXI_WREADY  <= !w_have_q && !S_AXI_WREADY;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_have_q     <= 1'b1;
        aw_addr_q     <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_have_q     <= 1'b1;
        w_data_q     <= S_AXI_WDATA;
        w_strb_q     <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_known(aw_addr_q) ? soe_cfg_pkg::RESP_OKAY
                                            : soe_cfg_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  function automatic logic wr_known(input logic [7:0] a);
    wr_known = (a == soe_cfg_pkg::CFG_STATUS_ADDR) || (a == soe_cfg_pkg::IRQ_ENABLE_ADDR)
            || (a == soe_cfg_pkg::IRQ_CLEAR_ADDR) || (a == soe_cfg_pkg::UNFREEZE_ADDR);
  endfunction : wr_known
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = wr_fire && (a == reg_addr);
  endfunction : hit

  // Config word; unused positions are not stored
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      cfg_q <= soe_cfg_pkg::CFG_RESET;
    else if (hit(aw_addr_q, soe_cfg_pkg::CFG_STATUS_ADDR))
    begin
      if (w_strb_q[0])
        cfg_q[7:0] <= w_data_q[7:0] & soe_cfg_pkg::CFG_WRITE_MASK[7:0];
      if (w_strb_q[1])
        cfg_q[15:8] <= w_data_q[15:8] & soe_cfg_pkg::CFG_WRITE_MASK[15:8];
    end
  end

  assign unfreeze_pulse = hit(aw_addr_q, soe_cfg_pkg::UNFREEZE_ADDR);

  // Status word: echoes and live conditions, gated by their enables
  logic fuse_live, aux_live, gnd_live;
  assign fuse_live = field_s2_q.fuse_blown && cfg_q[soe_cfg_pkg::BIT_FUSE_EN];
  assign aux_live  = field_s2_q.aux_fail && cfg_q[soe_cfg_pkg::BIT_AUX_EN];
  assign gnd_live  = field_s2_q.gnd_fault && cfg_q[soe_cfg_pkg::BIT_AUX_EN];

  always_comb
  begin
    status = cfg_q;
    status[soe_cfg_pkg::BIT_FUSE_BLOWN] = fuse_live;
    status[soe_cfg_pkg::BIT_AUX_FAIL]   = aux_live;
    status[soe_cfg_pkg::BIT_GND_FAULT]  = gnd_live;
  end

  // Read channel; forced error limits reads to status
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (S_AXI_ARADDR == soe_cfg_pkg::CFG_STATUS_ADDR)
      rd_word = {16'h0000, status};
    else if (S_AXI_ARADDR == soe_cfg_pkg::IRQ_STATUS_ADDR)
      rd_word = {28'h0000000, irq_status_q};
    else if (cfg_q[soe_cfg_pkg::BIT_FORCE_ERR])
      rd_ok = 1'b0;
    else if (S_AXI_ARADDR == soe_cfg_pkg::IRQ_ENABLE_ADDR)
      rd_word = {28'h0000000, irq_enable_q};
    else if (S_AXI_ARADDR == soe_cfg_pkg::FIELD_IN_ADDR)
      rd_word = {16'(CHATTER_FLAGS), 16'(contact_s2_q)};
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= soe_cfg_pkg::RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RDATA   <= rd_word;
        S_AXI_RRESP   <= rd_ok ? soe_cfg_pkg::RESP_OKAY : soe_cfg_pkg::RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end

  // Chatter supervision per channel
  logic [2:0]            chat_cnt_q [NUM_CH];
  logic [NUM_CH-1:0]     change;
  logic [31:0]           decay_cnt_q;
  logic                  decay_tick;
  logic                  run;

  assign run        = cfg_q[soe_cfg_pkg::BIT_CONFIGURE];
  assign change     = contact_s2_q ^ contact_prev_q;
  assign decay_tick = (decay_cnt_q == 32'(DECAY_CYCLES - 1));

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N || decay_tick)
      decay_cnt_q <= 32'h0000_0000;
    else
      decay_cnt_q <= decay_cnt_q + 32'h0000_0001;
  end

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_chat
    always_ff @(posedge REF_CLK)
    begin
      if (!RST_N || !run)
      begin
        chat_cnt_q[c]    <= 3'h0;
        CHATTER_FLAGS[c] <= 1'b0;
        EVENT_RECORD[c]  <= 1'b0;
      end
      else
      begin
        EVENT_RECORD[c] <= change[c] && (cfg_q[soe_cfg_pkg::BIT_CHAT_DIS]
                           || chat_cnt_q[c] < 3'(soe_cfg_pkg::CHATTER_LIMIT));
        if (cfg_q[soe_cfg_pkg::BIT_CHAT_CLR] && unfreeze_pulse)
          chat_cnt_q[c] <= 3'h0;
        else if (change[c] && chat_cnt_q[c] < 3'(soe_cfg_pkg::CHATTER_LIMIT))
          chat_cnt_q[c] <= chat_cnt_q[c] + 3'h1;
        else if (!cfg_q[soe_cfg_pkg::BIT_CHAT_CLR] && decay_tick && chat_cnt_q[c] != 3'h0)
          chat_cnt_q[c] <= chat_cnt_q[c] - 3'h1;
        CHATTER_FLAGS[c] <= !cfg_q[soe_cfg_pkg::BIT_CHAT_DIS]
                            && chat_cnt_q[c] >= 3'(soe_cfg_pkg::CHATTER_LIMIT);
      end
    end
  end

  // Indicators
  logic [31:0] comm_cnt_q;
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
      comm_cnt_q <= 32'h0000_0000;
    else if ((S_AXI_ARVALID && S_AXI_ARREADY) || wr_fire)
      comm_cnt_q <= 32'(COMM_CYCLES);
    else if (comm_cnt_q != 32'h0000_0000)
      comm_cnt_q <= comm_cnt_q - 32'h0000_0001;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      CHANNEL_STATE_INDICATORS <= '0;
      EXT_FAULT_LED            <= 1'b0;
      INT_FAULT_LED            <= 1'b0;
      COMM_LED                 <= 1'b0;
      MODULE_RUN               <= 1'b0;
    end
    else
    begin
      CHANNEL_STATE_INDICATORS <= contact_s2_q;
      EXT_FAULT_LED            <= gnd_live;
      INT_FAULT_LED            <= aux_live || cfg_q[soe_cfg_pkg::BIT_FORCE_ERR];
      COMM_LED                 <= comm_cnt_q != 32'h0000_0000;
      MODULE_RUN               <= run;
    end
  end

  // Interrupts: set wins over write-one-to-clear
  assign irq_events[soe_cfg_pkg::IRQ_FUSE]    = fuse_live;
  assign irq_events[soe_cfg_pkg::IRQ_AUX]     = aux_live;
  assign irq_events[soe_cfg_pkg::IRQ_GND]     = gnd_live && cfg_q[soe_cfg_pkg::BIT_GND_ATT_EN];
  assign irq_events[soe_cfg_pkg::IRQ_CHATTER] = |CHATTER_FLAGS;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_N)
    begin
      irq_status_q <= '0;
      irq_enable_q <= '0;
      IRQ          <= 1'b0;
    end
    else
    begin
      if (hit(aw_addr_q, soe_cfg_pkg::IRQ_CLEAR_ADDR))
        irq_status_q <= (irq_status_q & ~w_data_q[IRQ_BITS-1:0]) | irq_events;
      else
        irq_status_q <= irq_status_q | irq_events;
      if (hit(aw_addr_q, soe_cfg_pkg::IRQ_ENABLE_ADDR))
        irq_enable_q <= w_data_q[IRQ_BITS-1:0];
      IRQ <= |(irq_status_q & irq_enable_q);
    end
  end

  a_cfg_echo_read : assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == soe_cfg_pkg::CFG_STATUS_ADDR)
    |=> S_AXI_RVALID && S_AXI_RDATA[15:0] == $past(status))
    else $error("Status read mismatch");

  a_force_err_block : assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (S_AXI_ARVALID && S_AXI_ARREADY && cfg_q[1] && S_AXI_ARADDR == soe_cfg_pkg::FIELD_IN_ADDR)
    |=> S_AXI_RRESP == soe_cfg_pkg::RESP_SLVERR)
    else $error("Forced error read not refused");

  a_int_led_err : assert property (@(posedge REF_CLK) disable iff (!RST_N)
    cfg_q[1] && $stable(cfg_q) |=> INT_FAULT_LED)
    else $error("Internal LED off under forced error");

  a_ext_led_gnd : assert property (@(posedge REF_CLK) disable iff (!RST_N)
    gnd_live |=> EXT_FAULT_LED)
    else $error("External LED not following ground fault");

  a_aux_gated : assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !cfg_q[8] && !cfg_q[1] |=> !INT_FAULT_LED)
    else $error("Internal LED lit without enable");

  a_chan_led : assert property (@(posedge REF_CLK) disable iff (!RST_N)
    1'b1 |=> CHANNEL_STATE_INDICATORS == $past(contact_s2_q))
    else $error("Channel LED mismatch");

  a_chat_flag : assert property (@(posedge REF_CLK) disable iff (!RST_N)
    run && !cfg_q[12] && chat_cnt_q[0] < 3'h4 |=> !CHATTER_FLAGS[0])
    else $error("Chatter flag early");

  a_comm_led : assert property (@(posedge REF_CLK) disable iff (!RST_N)
    wr_fire |=> ##1 COMM_LED)
    else $error("Comm LED not lit after access");

endmodule : soe_contact_cfg_status
`default_nettype wire

//--- tb/soe_host_model.sv
// Host controller model: AXI4-Lite master that reads and writes module words
`timescale 1ns/1ps
`default_nettype none
module soe_host_model (
  input  wire logic        clk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial
  begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 0;
    r = 2'b11;
    @(posedge clk);
    awaddr  <= a;
    // Unused positions and fuse enable kept clear on the config word
    wdata   <= (a == soe_cfg_pkg::CFG_STATUS_ADDR) ? (d & 32'h0000_3503) : d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      n++;
      if (n > 200)
        tb_soe_contact_cfg_status.hang();
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata  <= ~wdata;
      end
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit done;
    n = 0;
    done = 0;
    r = 2'b11;
    d = '0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      n++;
      if (n > 200)
        tb_soe_contact_cfg_status.hang();
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1;
      end
    end
  endtask : rd
endmodule : soe_host_model
`default_nettype wire

//--- tb/tb_soe_contact_cfg_status.sv
// Self-checking bench for the contact input config/status bank
`timescale 1ns/1ps
`default_nettype none
module tb_soe_contact_cfg_status;
  logic                 ref_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready, ext_led, int_led, comm_led, run, irq;
  logic [7:0]           awaddr, araddr;
  logic [31:0]          wdata, rdata, d, cfg;
  logic [1:0]           bresp, rresp, r;
  logic [15:0]          contact, ind, chat, evr;
  soe_cfg_pkg::field_s  faults;
  int                   n_fail, tests_run, seed, k, st;
  int                   ev_n = 0;
  int                   cf[3] = '{32'h0001, 32'h2001, 32'h1001};
  int                   gap[3] = '{50, 10, 10};
  int                   nev[3] = '{6, 4, 6};

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) ev_n <= ev_n + evr[0];

  soe_host_model host_u (.clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // Short decay and comm windows keep the run brief
  soe_contact_cfg_status #(.NUM_CH(16), .DECAY_CYCLES(20), .COMM_CYCLES(20)) dut_u (
    .REF_CLK(ref_clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CONTACT_CLOSED(contact), .FIELD_FAULTS(faults), .CHANNEL_STATE_INDICATORS(ind),
    .CHATTER_FLAGS(chat), .EVENT_RECORD(evr), .EXT_FAULT_LED(ext_led), .INT_FAULT_LED(int_led),
    .COMM_LED(comm_led), .MODULE_RUN(run), .IRQ(irq));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  task automatic hang();
    n_fail++;
    give_verdict();
  endtask : hang

  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : settle

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    hang();
  end

  initial
  begin
    rst_n = 1'b0;
    contact = '0;
    faults = '0;
    n_fail = 0;
    tests_run = 0;
    seed = 29975;
    settle(5);
    rst_n <= 1'b1;
    settle(2);
    host_u.rd(soe_cfg_pkg::CFG_STATUS_ADDR, d, r);
    chk(d, 32'h0, "status after reset");
    chk(run, 1'b0, "run after reset");
    $display("reset test done");
    for (k = 0; k < 6; k++)
    begin
      cfg = $random(seed) & 32'h0000_3503;
      contact <= 16'($random(seed));
      host_u.wr(soe_cfg_pkg::CFG_STATUS_ADDR, cfg, r);
      chk(r, soe_cfg_pkg::RESP_OKAY, "config write resp");
      host_u.rd(soe_cfg_pkg::CFG_STATUS_ADDR, d, r);
      chk(d, cfg, "status echo");
      settle(4);
      chk(run, cfg[0], "run follows config");
      chk(int_led, cfg[1], "forced error led");
      chk(ind, contact, "channel indicators");
      chk(comm_led, 1'b1, "comm led active");
    end
    $display("config echo test done");
    host_u.wr(soe_cfg_pkg::CFG_STATUS_ADDR, 32'h2, r);
    host_u.rd(soe_cfg_pkg::FIELD_IN_ADDR, d, r);
    chk(r, soe_cfg_pkg::RESP_SLVERR, "non-status read refused");
    host_u.rd(soe_cfg_pkg::IRQ_STATUS_ADDR, d, r);
    chk(r, soe_cfg_pkg::RESP_OKAY, "status read allowed");
    host_u.wr(soe_cfg_pkg::CFG_STATUS_ADDR, 32'h0, r);
    host_u.rd(8'h60, d, r);
    chk(d, 32'h0, "unmapped read data");
    chk(r, soe_cfg_pkg::RESP_SLVERR, "unmapped read resp");
    host_u.wr(8'h60, 32'hFFFF_FFFF, r);
    chk(r, soe_cfg_pkg::RESP_SLVERR, "unmapped write");
    $display("refusal test done");
    // Chatter during the random loop may have left a sticky bit
    host_u.wr(soe_cfg_pkg::IRQ_CLEAR_ADDR, 32'hF, r);
    faults <= 3'b111;
    host_u.wr(soe_cfg_pkg::CFG_STATUS_ADDR, 32'h0501, r);
    settle(5);
    host_u.rd(soe_cfg_pkg::CFG_STATUS_ADDR, d, r);
    chk(d, 32'h0F01, "fault status bits");
    chk({ext_led, int_led}, 2'b11, "fault leds");
    host_u.wr(soe_cfg_pkg::IRQ_ENABLE_ADDR, 32'h2, r);
    settle(3);
    chk(irq, 1'b1, "irq on enabled event");
    host_u.rd(soe_cfg_pkg::IRQ_STATUS_ADDR, d, r);
    chk(d, 32'h6, "irq status");
    host_u.wr(soe_cfg_pkg::IRQ_ENABLE_ADDR, 32'h0, r);
    settle(3);
    chk(irq, 1'b0, "irq masked");
    faults <= 3'b000;
    settle(5);
    host_u.wr(soe_cfg_pkg::IRQ_CLEAR_ADDR, 32'hF, r);
    host_u.rd(soe_cfg_pkg::IRQ_STATUS_ADDR, d, r);
    chk(d, 32'h0, "irq cleared");
    faults <= 3'b010;
    host_u.wr(soe_cfg_pkg::CFG_STATUS_ADDR, 32'h0001, r);
    settle(5);
    chk(int_led, 1'b0, "aux led needs bit 8");
    faults <= 3'b000;
    $display("fault and irq test done");
    for (k = 0; k < 3; k++)
    begin
      host_u.wr(soe_cfg_pkg::CFG_STATUS_ADDR, cf[k], r);
      settle(100);
      host_u.wr(soe_cfg_pkg::UNFREEZE_ADDR, 32'h0, r);
      settle(5);
      st = ev_n;
      repeat (6)
      begin
        contact[0] <= ~contact[0];
        settle(gap[k]);
      end
      chk(ev_n - st, nev[k], "recorded events");
      chk(chat[0], k == 1, "chatter flag");
      if (k == 1)
      begin
        host_u.wr(soe_cfg_pkg::UNFREEZE_ADDR, 32'h0, r);
        settle(5);
        chk(chat[0], 1'b0, "flag cleared on unfreeze");
      end
    end
    $display("chatter test done");
    settle(30);
    chk(comm_led, 1'b0, "comm led idle");
    $display("comm test done");
    give_verdict();
  end
endmodule : tb_soe_contact_cfg_status
`default_nettype wire
